// >>> cfgld_host.sv
/*
 * host end: AHB-Lite register slave that drives the request, the
 * configuration clock, the data words and the user init clock.
 * assumes a single AHB-Lite master issuing single word transfers.
 */
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cfgld_host #(
    parameter int NOWATCH_CYC = cfgld_pkg::NOWATCH_CYC
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // link to the device
    cfgld_link_if.host LNK
);
    typedef enum logic [2:0] {H_IDLE, H_REQ_LOW, H_WAIT_RDY, H_GAP, H_SEND, H_TAIL, H_DONE} cfgld_hstate_t;

    cfgld_hstate_t state_reg;
    cfgld_pkg::cfgld_cnt_t cnt_reg;
    logic rdy_s1, rdy_s2, done_s1, done_s2;
    logic watch_reg, err_reg, full_reg, start, word_sent, abort;
    logic [7:0] div_reg, ratio_reg, div_cnt_reg, edge_cnt_reg;
    logic [31:0] word_reg;
    logic wr_pend_reg, dp_wr_reg;
    logic [7:0] dp_addr_reg;
    logic tick, config_clock_in_reg, usr_reg, req_reg;

    // ----
    // AHB-Lite slave
    // ----
    logic a_take;
    assign a_take = HSEL & HREADY & HTRANS[1];

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            HRDATA <= '0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            dp_wr_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            dp_addr_reg <= '0;
        end else begin
            dp_wr_reg <= a_take & HWRITE;
            if (wr_pend_reg && !full_reg) begin
                wr_pend_reg <= 1'b0;
                HREADYOUT <= 1'b1;
            end
            if (a_take) begin
                dp_addr_reg <= HADDR[7:0];
                unique case (HADDR[7:0])
                    cfgld_pkg::REG_CTRL: HRDATA <= {30'h0, watch_reg, 1'b0};
                    cfgld_pkg::REG_STATUS: HRDATA <= {27'h0, full_reg, err_reg, done_s2, rdy_s2,
                        (state_reg != H_IDLE) && (state_reg != H_DONE)};
                    cfgld_pkg::REG_DIV: HRDATA <= {24'h0, div_reg};
                    cfgld_pkg::REG_RATIO: HRDATA <= {24'h0, ratio_reg};
                    default: HRDATA <= '0;
                endcase
                // a data write to a full holding word stalls the bus
                if (HWRITE && HADDR[7:0] == cfgld_pkg::REG_DATA) begin
                    wr_pend_reg <= 1'b1;
                    HREADYOUT <= ~(full_reg | wr_pend_reg);
                end
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            watch_reg <= cfgld_pkg::WATCH_RST;
            div_reg <= cfgld_pkg::DIV_RST;
            ratio_reg <= cfgld_pkg::RATIO_RST;
        end else if (dp_wr_reg) begin
            if (dp_addr_reg == cfgld_pkg::REG_CTRL) begin
                watch_reg <= HWDATA[cfgld_pkg::CTRL_WATCH_BIT];
            end
            // half periods below two would outrun the device sampler
            if (dp_addr_reg == cfgld_pkg::REG_DIV) begin
                div_reg <= (HWDATA[7:0] < 8'h02) ? 8'h02 : HWDATA[7:0];
            end
            if (dp_addr_reg == cfgld_pkg::REG_RATIO) begin
                ratio_reg <= (HWDATA[7:0] == 8'h00) ? 8'h01 : HWDATA[7:0];
            end
        end
    end

    assign start = dp_wr_reg && dp_addr_reg == cfgld_pkg::REG_CTRL && HWDATA[cfgld_pkg::CTRL_START_BIT]
        && (state_reg == H_IDLE || state_reg == H_DONE);

    // holding word: loaded by the bus, freed once its N clocks are out
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            word_reg <= '0;
            full_reg <= 1'b0;
        end else if (wr_pend_reg && !full_reg) begin
            word_reg <= HWDATA;
            full_reg <= 1'b1;
        end else if (word_sent || abort) begin
            full_reg <= 1'b0;
        end
    end

    // ----
    // link sequencing
    // ----
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            div_cnt_reg <= '0;
        end else begin
            rdy_s1 <= LNK.device_ready_line;
            rdy_s2 <= rdy_s1;
            done_s1 <= LNK.load_complete_flag;
            done_s2 <= done_s1;
            div_cnt_reg <= tick ? 8'h00 : div_cnt_reg + 8'h01;
        end
    end

    assign tick = (div_cnt_reg + 8'h01 >= div_reg);
    assign abort = !rdy_s2 && (state_reg == H_GAP || state_reg == H_SEND || state_reg == H_TAIL);
    assign word_sent = state_reg == H_SEND && tick && config_clock_in_reg && edge_cnt_reg == ratio_reg;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            state_reg <= H_IDLE;
            cnt_reg <= '0;
            req_reg <= 1'b1;
            config_clock_in_reg <= 1'b0;
            usr_reg <= 1'b0;
            edge_cnt_reg <= '0;
            err_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            if (tick) begin
                usr_reg <= ~usr_reg;
            end
            if (abort) begin
                err_reg <= 1'b1;
            end else if (start) begin
                err_reg <= 1'b0;
            end
            unique case (state_reg)
                H_IDLE, H_DONE: begin
                    if (start) begin
                        state_reg <= H_REQ_LOW;
                        req_reg <= 1'b0;
                        cnt_reg <= '0;
                    end
                end
                H_REQ_LOW: begin
                    if (cnt_reg >= cfgld_pkg::cfgld_cnt_t'(cfgld_pkg::REQ_LOW_CYC - 1)) begin
                        state_reg <= H_WAIT_RDY;
                        req_reg <= 1'b1;
                        cnt_reg <= '0;
                    end
                end
                H_WAIT_RDY: begin
                    if (watch_reg && rdy_s2 && cnt_reg > cfgld_pkg::cfgld_cnt_t'(4)) begin
                        state_reg <= H_GAP;
                        cnt_reg <= '0;
                    end else if (!watch_reg && cnt_reg >= cfgld_pkg::cfgld_cnt_t'(NOWATCH_CYC - 1)) begin
                        state_reg <= H_SEND;
                        edge_cnt_reg <= '0;
                    end
                end
                H_GAP: begin
                    if (abort) begin
                        state_reg <= H_IDLE;
                    end else if (cnt_reg >= cfgld_pkg::cfgld_cnt_t'(cfgld_pkg::RDY_GAP_CYC - 1)) begin
                        state_reg <= H_SEND;
                        edge_cnt_reg <= '0;
                    end
                end
                H_SEND: begin
                    if (abort) begin
                        state_reg <= H_IDLE;
                        config_clock_in_reg <= 1'b0;
                    end else if (done_s2 && !full_reg && !config_clock_in_reg) begin
                        state_reg <= H_TAIL;
                        edge_cnt_reg <= '0;
                    end else if (full_reg && tick) begin
                        // word stays on the pins through all N periods
                        config_clock_in_reg <= ~config_clock_in_reg;
                        if (!config_clock_in_reg) begin
                            edge_cnt_reg <= edge_cnt_reg + 8'h01;
                        end else if (word_sent) begin
                            edge_cnt_reg <= '0;
                        end
                    end
                end
                H_TAIL: begin
                    if (abort) begin
                        state_reg <= H_IDLE;
                        config_clock_in_reg <= 1'b0;
                    end else if (tick) begin
                        config_clock_in_reg <= ~config_clock_in_reg;
                        if (config_clock_in_reg) begin
                            edge_cnt_reg <= edge_cnt_reg + 8'h01;
                            if (edge_cnt_reg == 8'h01) begin
                                state_reg <= H_DONE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    assign LNK.config_request_n = req_reg;
    assign LNK.config_clock_in = config_clock_in_reg;
    assign LNK.cfg_data = word_reg;
    assign LNK.user_init_clock = usr_reg;
    assign LNK.ready_host_oe = 1'b0;
endmodule : cfgld_host
`default_nettype wire

// >>> cfgld_pkg.sv
/*
 * constants shared by both ends of the configuration-load link:
 * timing counts, host register map, field positions, reset values.
 * assumes a 100 MHz MCLK on both ends.
 */
package cfgld_pkg;
    // ----
    // clock and counter types
    // ----
    localparam int CLK_PERIOD_NS = 10;
    localparam int CNT_W = 26;
    typedef logic [CNT_W-1:0] cfgld_cnt_t;
    localparam int DATA_W = 32;
    localparam int MODE_SELECT_PINS_W = 5;
    localparam int MODE_SELECT_PINS_FAST_BIT = 0;
    localparam int CFG_WORDS_DEF = 16;
    localparam int USR_INIT_EDGES = 8576;

    // ----
    // times as printed, and their cycle counts
    // ----
    localparam int POR_FAST_MIN_MS = 4;
    localparam int POR_STD_MIN_MS = 100;
    localparam int STATUS_MIN_US = 268;
    localparam int OSC_INIT_MIN_US = 175;
    localparam int REQ_LOW_MIN_US = 2;
    localparam int RDY_TO_CLK_MIN_US = 2;
    localparam int REQ_TO_CLK_MIN_US = 1506;
    localparam int CLK_MIN_PERIOD_NS = 10;
    localparam int CU_MIN_NS = 4 * CLK_MIN_PERIOD_NS;
    localparam int POR_FAST_CYC = (POR_FAST_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_STD_CYC = (POR_STD_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_INIT_CYC = (OSC_INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REQ_LOW_CYC = (REQ_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RDY_GAP_CYC = (RDY_TO_CLK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NOWATCH_CYC = (REQ_TO_CLK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CU_CYC = (CU_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----
    // host register map
    // ----
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_DIV = 8'h0c;
    localparam logic [7:0] REG_RATIO = 8'h10;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WATCH_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_ERR_BIT = 3;
    localparam int ST_FULL_BIT = 4;
    localparam logic [7:0] DIV_RST = 8'h08;
    localparam logic [7:0] RATIO_RST = 8'h01;
    localparam logic WATCH_RST = 1'b1;
endpackage : cfgld_pkg

// >>> cfgld_link_if.sv
/*
 * link wires between the configuration host and the device.
 * assumes a pull-up on the open-drain ready line.
 */
`timescale 1ns/10ps
`default_nettype none
interface cfgld_link_if;
    logic config_request_n;
    logic ready_dev_oe;
    logic ready_host_oe;
    logic device_ready_line;
    logic load_complete_flag;
    logic config_clock_in;
    logic [cfgld_pkg::DATA_W-1:0] cfg_data;
    logic user_init_clock;

    // open-drain: either end pulls low, pull-up otherwise
    assign device_ready_line = ~(ready_dev_oe | ready_host_oe);

    modport dev (
        input config_request_n, config_clock_in, cfg_data, user_init_clock, device_ready_line,
        output ready_dev_oe, load_complete_flag
    );
    modport host (
        output config_request_n, config_clock_in, cfg_data, user_init_clock, ready_host_oe,
        input device_ready_line, load_complete_flag
    );
endinterface : cfgld_link_if
`default_nettype wire

// >>> cfgld_device.sv
/*
 * device end of the parallel configuration load: power-on delay,
 * request handshake, word capture and initialization to user mode.
 * assumes link pins are asynchronous to MCLK and that the host keeps
 * its own side of the handshake.
 */
// Summary of operation
// - fast power-on delay holds ready low 4-12 ms
// - standard delay holds ready low 100-300 ms
// - mode-select pins choose fast or standard delay
// - request fall drops load-complete within 600 ns
// - request fall pulls ready low within 600 ns
// - host holds request low at least 2 us
// - ready low pulse 268 to 1506 us
// - ready released within 1506 us after request
// - watching host waits 2 us before clock
// - blind host waits 1506 us before clock
// - capture on rising edge, word held N periods
// - ratio above one with decompression or security
// - oscillator init reaches user mode in 175-437 us
// - user clock enabled after 4 clock periods
// - user clock init takes 8576 cycles
// - request falling edge restarts configuration
// - load-complete low until all data received
// - host sends two falling edges after done
`timescale 1ns/10ps
`default_nettype none
module cfgld_device #(
    parameter int POR_FAST_CYC = cfgld_pkg::POR_FAST_CYC,
    parameter int POR_STD_CYC = cfgld_pkg::POR_STD_CYC,
    parameter int STATUS_CYC = cfgld_pkg::STATUS_CYC,
    parameter int OSC_INIT_CYC = cfgld_pkg::OSC_INIT_CYC,
    parameter int CFG_WORDS = cfgld_pkg::CFG_WORDS_DEF,
    parameter int MODE_SELECT_PINS_W = cfgld_pkg::MODE_SELECT_PINS_W
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // link to the host
    cfgld_link_if.dev LNK,
    // straps and options
    input wire logic [MODE_SELECT_PINS_W-1:0] MODE_SELECT,
    input wire logic USE_USER_CLK,
    input wire logic [7:0] WORD_RATIO,
    // captured data and status
    output logic [cfgld_pkg::DATA_W-1:0] WORD_DATA,
    output logic WORD_VALID,
    output logic USER_MODE
);
    typedef enum logic [3:0] {
        D_POR, D_CFG_RESET, D_STATUS, D_LOAD, D_WAIT_EDGES,
        D_INIT_OSC, D_INIT_CU, D_INIT_USR, D_USER
    } cfgld_dstate_t;

    cfgld_dstate_t state_reg, state_next;
    cfgld_pkg::cfgld_cnt_t cnt_reg;
    logic cnt_step;

    // ----
    // synchronisers
    // ----
    logic req_s1, req_s2;
    logic clk_s1, clk_s2, clk_s3;
    logic usr_s1, usr_s2, usr_s3;
    logic [cfgld_pkg::DATA_W-1:0] dat_s1, dat_s2;
    logic [MODE_SELECT_PINS_W-1:0] mode_select_pins_s1, mode_select_pins_s2;
    logic clk_rise, clk_fall, usr_rise;

    // data goes through the same two stages as the clock so both line up
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            req_s1 <= 1'b1;
            req_s2 <= 1'b1;
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            usr_s1 <= 1'b0;
            usr_s2 <= 1'b0;
            usr_s3 <= 1'b0;
            dat_s1 <= '0;
            dat_s2 <= '0;
            mode_select_pins_s1 <= '0;
            mode_select_pins_s2 <= '0;
        end else begin
            req_s1 <= LNK.config_request_n;
            req_s2 <= req_s1;
            clk_s1 <= LNK.config_clock_in;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            usr_s1 <= LNK.user_init_clock;
            usr_s2 <= usr_s1;
            usr_s3 <= usr_s2;
            dat_s1 <= LNK.cfg_data;
            dat_s2 <= dat_s1;
            mode_select_pins_s1 <= MODE_SELECT;
            mode_select_pins_s2 <= mode_select_pins_s1;
        end
    end

    assign clk_rise = clk_s2 & ~clk_s3;
    assign clk_fall = ~clk_s2 & clk_s3;
    assign usr_rise = usr_s2 & ~usr_s3;

    // ----
    // sequencing
    // ----
    logic [15:0] word_cnt_reg;
    logic [7:0] edge_cnt_reg;
    logic [7:0] ratio_eff;
    cfgld_pkg::cfgld_cnt_t por_limit;

    assign ratio_eff = (WORD_RATIO == 8'h00) ? 8'h01 : WORD_RATIO;
    // strap level picks the delay; sampled level is read throughout the delay
    assign por_limit = mode_select_pins_s2[cfgld_pkg::MODE_SELECT_PINS_FAST_BIT] ?
        cfgld_pkg::cfgld_cnt_t'(POR_FAST_CYC) : cfgld_pkg::cfgld_cnt_t'(POR_STD_CYC);

    always_comb begin
        state_next = state_reg;
        cnt_step = 1'b1;
        unique case (state_reg)
            D_POR: begin
                if (cnt_reg >= por_limit - 1'b1) begin
                    state_next = D_LOAD;
                end
            end
            D_CFG_RESET: begin
                if (req_s2) begin
                    state_next = D_STATUS;
                end
            end
            D_STATUS: begin
                // low pulse already spans the request low time
                if (cnt_reg >= cfgld_pkg::cfgld_cnt_t'(STATUS_CYC - 1)) begin
                    state_next = D_LOAD;
                end
            end
            D_LOAD: begin
                cnt_step = 1'b0;
                if (word_cnt_reg == 16'(CFG_WORDS)) begin
                    state_next = D_WAIT_EDGES;
                end
            end
            D_WAIT_EDGES: begin
                cnt_step = clk_fall;
                if (clk_fall && cnt_reg == cfgld_pkg::cfgld_cnt_t'(1)) begin
                    state_next = USE_USER_CLK ? D_INIT_CU : D_INIT_OSC;
                end
            end
            D_INIT_OSC: begin
                if (cnt_reg >= cfgld_pkg::cfgld_cnt_t'(OSC_INIT_CYC - 1)) begin
                    state_next = D_USER;
                end
            end
            D_INIT_CU: begin
                if (cnt_reg >= cfgld_pkg::cfgld_cnt_t'(cfgld_pkg::CU_CYC - 1)) begin
                    state_next = D_INIT_USR;
                end
            end
            D_INIT_USR: begin
                cnt_step = usr_rise;
                if (usr_rise && cnt_reg == cfgld_pkg::cfgld_cnt_t'(cfgld_pkg::USR_INIT_EDGES - 1)) begin
                    state_next = D_USER;
                end
            end
            D_USER: begin
                cnt_step = 1'b0;
            end
        endcase
        // a low request outside power-on restarts everything
        if (state_reg != D_POR && !req_s2) begin
            state_next = D_CFG_RESET;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            state_reg <= D_POR;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + cfgld_pkg::cfgld_cnt_t'(cnt_step);
            end
        end
    end

    // ----
    // word capture
    // ----
    // only the first rising edge of each group of N takes the word
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            word_cnt_reg <= '0;
            edge_cnt_reg <= '0;
            WORD_DATA <= '0;
            WORD_VALID <= 1'b0;
        end else begin
            WORD_VALID <= 1'b0;
            if (state_reg != D_LOAD) begin
                word_cnt_reg <= '0;
                edge_cnt_reg <= '0;
            end else if (clk_rise && word_cnt_reg != 16'(CFG_WORDS)) begin
                if (edge_cnt_reg == 8'h00) begin
                    WORD_DATA <= dat_s2;
                    WORD_VALID <= 1'b1;
                    word_cnt_reg <= word_cnt_reg + 16'h0001;
                end
                edge_cnt_reg <= (edge_cnt_reg + 8'h01 == ratio_eff) ? 8'h00 : edge_cnt_reg + 8'h01;
            end
        end
    end

    // ----
    // pin drivers
    // ----
    logic ready_oe_reg, done_reg;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ready_oe_reg <= 1'b1;
            done_reg <= 1'b0;
            USER_MODE <= 1'b0;
        end else begin
            ready_oe_reg <= (state_next == D_POR) || (state_next == D_CFG_RESET)
                || (state_next == D_STATUS);
            done_reg <= (state_next == D_WAIT_EDGES) || (state_next == D_INIT_OSC)
                || (state_next == D_INIT_CU) || (state_next == D_INIT_USR)
                || (state_next == D_USER);
            USER_MODE <= (state_next == D_USER);
        end
    end

    assign LNK.ready_dev_oe = ready_oe_reg;
    assign LNK.load_complete_flag = done_reg;
endmodule : cfgld_device
`default_nettype wire

// >>> cfgld_properties.sv
/* link assertions for the configuration load handshake.
   assumes cfgld_link_if signals, MCLK domain, shortened device counts. */
`timescale 1ns/10ps
`default_nettype none
module cfgld_properties #(
    parameter int STATUS_CYC = 100
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // link wires
    input wire logic config_request_n,
    input wire logic device_ready_line,
    input wire logic load_complete_flag,
    input wire logic config_clock_in,
    input wire logic [cfgld_pkg::DATA_W-1:0] cfg_data
);
    // ----
    // helper counts: low request, high ready, ready low after release
    // ----
    int req_lo_cnt;
    int rdy_hi_cnt;
    int rq_cnt;
    logic seen_req;
    always_ff @(posedge MCLK) begin
        req_lo_cnt <= (!NRST || config_request_n) ? 0 : req_lo_cnt + 1;
        rdy_hi_cnt <= (!NRST || !device_ready_line) ? 0 : rdy_hi_cnt + 1;
    end
    // power-on low time is not a request; only count once a request was seen
    always_ff @(posedge MCLK) begin
        seen_req <= NRST && (seen_req || !config_request_n);
        rq_cnt <= (!NRST || !seen_req || !config_request_n || device_ready_line) ? 0 : rq_cnt + 1;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // ----
    // assertions
    // ----
    req_flag_low_a: assert property ($fell(config_request_n) |-> ##[0:4] !load_complete_flag)
        else $error("flag still high");
    req_ready_low_a: assert property ($fell(config_request_n) |-> ##[0:4] !device_ready_line)
        else $error("ready not pulled low");
    ready_low_min_a: assert property ($rose(device_ready_line) && seen_req |-> rq_cnt >= STATUS_CYC)
        else $error("ready low pulse too short");
    ready_release_a: assert property (rq_cnt <= STATUS_CYC + 8)
        else $error("ready line not released in time");
    ready_stays_a: assert property ($fell(device_ready_line) |-> !config_request_n)
        else $error("ready dropped alone");
    flag_cause_a: assert property ($rose(load_complete_flag) |-> device_ready_line && config_request_n)
        else $error("load complete raised outside a load");
    flag_stands_a: assert property (load_complete_flag && config_request_n |=> load_complete_flag)
        else $error("flag dropped alone");
    req_pulse_a: assert property ($rose(config_request_n) |-> req_lo_cnt >= cfgld_pkg::REQ_LOW_CYC)
        else $error("request low pulse too short");
    clock_gap_a: assert property ($rose(config_clock_in) |-> rdy_hi_cnt >= cfgld_pkg::RDY_GAP_CYC)
        else $error("clock too soon");
    word_hold_a: assert property ($rose(config_clock_in) |-> $stable(cfg_data) [*2])
        else $error("word not held");
    cover property ($fell(config_request_n));
    cover property ($rose(load_complete_flag));
    cover property ($rose(device_ready_line) && seen_req);
endmodule : cfgld_properties
`default_nettype wire

// >>> cfgld_test.sv
/* self-checking bench: host and device joined by cfgld_link_if.
   assumes shortened counts; software side driven over AHB-Lite. */
`timescale 1ns/10ps
`default_nettype none
module cfgld_test;
    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [4:0] mode_select_pins = 5'h01;
    logic [7:0] ratio = 8'h01;
    logic uclk = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic hresp;
    logic [31:0] wdata;
    logic wvalid;
    logic umode;
    logic [31:0] q;
    logic [31:0] got[$];
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    typedef struct {logic [4:0] m; int por;} cfgld_row_t;
    cfgld_row_t rows[4] = '{'{5'h01, 200}, '{5'h00, 400}, '{5'h1f, 200}, '{5'h1e, 400}};
    always #5 MCLK = ~MCLK;
    cfgld_link_if lnk ();
    cfgld_device #(.POR_FAST_CYC(200), .POR_STD_CYC(400), .STATUS_CYC(100), .OSC_INIT_CYC(100))
        cfgld_device_i (.MCLK(MCLK), .NRST(NRST), .LNK(lnk.dev), .MODE_SELECT(mode_select_pins), .USE_USER_CLK(uclk),
        .WORD_RATIO(ratio), .WORD_DATA(wdata), .WORD_VALID(wvalid), .USER_MODE(umode));
    cfgld_host #(.NOWATCH_CYC(400)) cfgld_host_i (.MCLK(MCLK), .NRST(NRST), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .LNK(lnk.host));
    cfgld_properties cfgld_properties_i (.MCLK(MCLK), .NRST(NRST),
        .config_request_n(lnk.config_request_n), .device_ready_line(lnk.device_ready_line),
        .load_complete_flag(lnk.load_complete_flag), .config_clock_in(lnk.config_clock_in),
        .cfg_data(lnk.cfg_data));
    // ----
    // capture monitor and hang guard
    // ----
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (wvalid === 1'b1) got.push_back(wdata);
        if (cyc == 50000) begin
            n_errors++;
            summarize();
        end
    end
    // ----
    // tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, input int hi, input int s);
        n_tests++;
        if (s < lo || s > hi) begin
            n_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, s);
        end
    endtask : chk_rng
    // called just after a rising edge; no fixed latency assumed
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge MCLK);
        while (hreadyout !== 1'b1) @(posedge MCLK);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge MCLK);
        while (hreadyout !== 1'b1) @(posedge MCLK);
        q = hrdata;
    endtask : ahb
    task automatic load(input logic [7:0] n, input logic [31:0] base, input logic u);
        int t;
        ratio <= n;
        uclk <= u;
        ahb(1'b1, cfgld_pkg::REG_RATIO, {24'h0, n});
        ahb(1'b1, cfgld_pkg::REG_DIV, 32'h2);
        got.delete();
        // with the user clock the host also stops watching ready
        ahb(1'b1, cfgld_pkg::REG_CTRL, {30'h0, !u, 1'b1});
        for (int i = 0; i < cfgld_pkg::CFG_WORDS_DEF; i++) ahb(1'b1, cfgld_pkg::REG_DATA, base + i);
        while (lnk.load_complete_flag !== 1'b1) @(posedge MCLK);
        t = 0;
        while (umode !== 1'b1) begin
            @(posedge MCLK);
            t++;
        end
        // user clock period is two DIV half periods, 4 cycles
        if (u) chk_rng("user init", 4 * cfgld_pkg::USR_INIT_EDGES - 4, 4 * cfgld_pkg::USR_INIT_EDGES + 64, t);
        else chk_rng("init time", 100, 160, t);
        chk("word count", 32'(cfgld_pkg::CFG_WORDS_DEF), got.size());
        for (int i = 0; i < cfgld_pkg::CFG_WORDS_DEF; i++) chk("word", base + i, got[i]);
        ahb(1'b0, cfgld_pkg::REG_STATUS, 32'h0);
        chk("status", 32'h6, q & 32'he);
        chk("okay", 32'h0, 32'(hresp));
    endtask : load
    task automatic summarize();
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // ----
    // main sequence: power-on table, registers, loads
    // ----
    initial begin
        int w;
        for (int r = 0; r < 4; r++) begin
            mode_select_pins <= rows[r].m;
            NRST <= 1'b0;
            repeat (20) @(posedge MCLK);
            NRST <= 1'b1;
            w = 0;
            while (lnk.device_ready_line !== 1'b1) begin
                @(posedge MCLK);
                w++;
            end
            chk_rng("power-on delay", rows[r].por, rows[r].por + 8, w);
        end
        ahb(1'b0, cfgld_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h2, q);
        ahb(1'b0, cfgld_pkg::REG_DIV, 32'h0);
        chk("div reset", 32'h8, q);
        ahb(1'b1, 8'h20, 32'hffffffff);
        ahb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, q);
        load(8'h01, 32'h10000000, 1'b0);
        // restarts from user mode
        load(8'h03, 32'ha5a50000, 1'b0);
        load(8'h02, 32'h5a5a0000, 1'b1);
        summarize();
    end
endmodule : cfgld_test
`default_nettype wire
